// *** ldo_analog_model.sv ***
/*
 * Comparator side of four linear regulators: power-good per channel.
 * Assumes the bench commands undervoltage dips through dip, per channel.
 */
`timescale 1ns/1ps
module ldo_analog_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [ldo_pkg::NCH-1:0] dip,
	output logic [ldo_pkg::NCH-1:0] pg_ok
);
	// -------------------------------------------
	// Comparators
	// -------------------------------------------
	// Registered so pg_ok is synchronous to pclk, as the design expects
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pg_ok <= 4'hF;
		end else begin
			pg_ok <= ~dip;
		end
	end
endmodule : ldo_analog_model

// *** ldo_channel.sv ***
/*
 * One linear regulator channel: on/off edge detect, turn-on delay,
 * discharge and bias drive, voltage decode.
 * Assumes settings come from registers in the clock domain of pclk.
 */
`timescale 1ns/1ps
module ldo_channel #(
	parameter int UNIT_CYC = ldo_pkg::DELAY_UNIT_CYC,
	parameter int CNT_W = 24
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic on_bit,
	input wire logic [ldo_pkg::DLY_W-1:0] delay_code,
	input wire logic dis_bit,
	input wire logic bias_bit,
	input wire logic [ldo_pkg::VC_W-1:0] vcode,
	output logic reg_en,
	output logic discharge_on,
	output logic low_bias,
	output logic [ldo_pkg::MV_W-1:0] vout_mv
);
	typedef struct packed {
		logic on_prev;
		logic busy;
		logic [CNT_W-1:0] cnt;
		logic en;
		logic dis;
		logic bias;
		logic [ldo_pkg::MV_W-1:0] mv;
	} chan_s;
	chan_s q;
	chan_s d;
	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		d.on_prev = on_bit;
		if (on_bit && !q.on_prev) begin
			if (delay_code == 3'h0) begin
				d.en = 1'b1;
			end else begin
				d.busy = 1'b1;
				d.cnt = CNT_W'(UNIT_CYC) << (delay_code - 3'h1);
			end
		end else if (!on_bit && q.on_prev) begin
			d.en = 1'b0;
			d.busy = 1'b0;
			d.cnt = '0;
		end else if (q.busy) begin
			if (q.cnt <= CNT_W'(1)) begin
				d.en = 1'b1;
				d.busy = 1'b0;
				d.cnt = '0;
			end else begin
				d.cnt = q.cnt - CNT_W'(1);
			end
		end
		d.dis = dis_bit && !d.en;
		d.bias = bias_bit;
		d.mv = ldo_pkg::vcode_to_mv(vcode);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign reg_en = q.en;
	assign discharge_on = q.dis;
	assign low_bias = q.bias;
	assign vout_mv = q.mv;
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_edge_only;
		$stable(on_bit) && !q.busy |=> $stable(q.en);
	endproperty
	a_edge_only: assert property (p_edge_only) else $error("enable moved without edge");
	property p_cancel;
		!on_bit && q.on_prev |=> !q.en && !q.busy;
	endproperty
	a_cancel: assert property (p_cancel) else $error("disable edge did not cancel");
	property p_delay_start;
		on_bit && !q.on_prev && delay_code != 3'h0 |=> !q.en && q.busy;
	endproperty
	a_delay_start: assert property (p_delay_start) else $error("delay not started");
	property p_discharge;
		q.dis |-> !q.en && $past(dis_bit);
	endproperty
	a_discharge: assert property (p_discharge) else $error("discharge while enabled");
	property p_grid;
		vcode == 6'h3F |=> q.mv == ldo_pkg::V_MAX_MV;
	endproperty
	a_grid: assert property (p_grid) else $error("top code not 3.900 V");
endmodule : ldo_channel

// *** ldo_channel_control.sv ***
/*
 * Control of four linear regulator channels behind an APB3 slave,
 * with a fault interrupt driven active low.
 * Assumes power-good inputs are synchronous to pclk, high when good.
 */
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ldo_channel_control #(
	parameter int DELAY_UNIT_CYC = ldo_pkg::DELAY_UNIT_CYC,
	parameter logic [5:0] DEF_VCODE = ldo_pkg::DEF_VCODE
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ldo_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [ldo_pkg::NCH-1:0] pg_ok,
	output logic [ldo_pkg::NCH-1:0] reg_en,
	output logic [ldo_pkg::NCH-1:0] discharge_on,
	output logic [ldo_pkg::NCH-1:0] low_bias,
	output logic [ldo_pkg::NCH*ldo_pkg::MV_W-1:0] vout_mv,
	output logic irq_out_n
);
	localparam int NCH = ldo_pkg::NCH;
	localparam int CFG_W = ldo_pkg::CFG_W;
	typedef struct packed {
		logic [NCH-1:0][CFG_W-1:0] cfg;
		logic sys_en;
		logic [NCH-1:0] stat;
		logic [NCH-1:0] mask;
		logic [NCH-1:0] pg_prev;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic irq_n;
	} ctrl_s;
	ctrl_s q;
	ctrl_s d;
	logic setup;
	logic access;
	logic ch_hit;
	logic [1:0] ch_idx;
	logic [NCH-1:0] fault;
	logic [NCH-1:0] ack;
	logic [NCH-1:0][ldo_pkg::VC_W-1:0] vapp;
	// ---------------------------------------------------------------
	// Address decode
	// ---------------------------------------------------------------
	assign setup = psel && !penable;
	assign access = psel && penable && q.ready;
	assign ch_hit = (paddr >= ldo_pkg::CH_BASE)
		&& (paddr < ldo_pkg::SYS_EN)
		&& (paddr[1:0] == 2'h0);
	assign ch_idx = paddr[3:2];
	// Falling edge only, so a channel that stays low is reported once
	assign fault = q.pg_prev & ~pg_ok;
	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		d = q;
		ack = '0;
		d.pg_prev = pg_ok;
		d.ready = setup;
		if (setup) begin
			d.rdata = 32'h0000_0000;
			d.err = 1'b0;
			if (ch_hit) begin
				d.rdata[CFG_W-1:0] = q.cfg[ch_idx];
				d.rdata[ldo_pkg::F_PG] = pg_ok[ch_idx];
			end else if (paddr == ldo_pkg::SYS_EN) begin
				d.rdata[0] = q.sys_en;
			end else if (paddr == ldo_pkg::IRQ_STAT) begin
				d.rdata[NCH-1:0] = q.stat;
			end else if (paddr == ldo_pkg::IRQ_MASK) begin
				d.rdata[NCH-1:0] = q.mask;
			end else begin
				d.err = 1'b1;
			end
		end
		if (access && !q.err) begin
			if (pwrite) begin
				if (ch_hit) begin
					d.cfg[ch_idx] = pwdata[CFG_W-1:0];
				end else if (paddr == ldo_pkg::SYS_EN) begin
					d.sys_en = pwdata[0];
				end else if (paddr == ldo_pkg::IRQ_STAT) begin
					ack = pwdata[NCH-1:0];
				end else if (paddr == ldo_pkg::IRQ_MASK) begin
					d.mask = pwdata[NCH-1:0];
				end
			end else if (ch_hit) begin
				// Reading the power-good flag acknowledges the fault
				ack[ch_idx] = 1'b1;
			end
		end
		// A fault in the clearing cycle survives the clear
		d.stat = (q.stat & ~ack) | fault;
		d.irq_n = ~|(d.stat & d.mask);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
			q.pg_prev <= '1;
			q.irq_n <= 1'b1;
		end else begin
			q <= d;
		end
	end
	// ---------------------------------------------------------------
	// Channels
	// ---------------------------------------------------------------
	// Voltage codes only steer the analog side once the system is enabled
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			vapp[i] = q.sys_en ? q.cfg[i][ldo_pkg::F_VC +: ldo_pkg::VC_W] : DEF_VCODE;
		end
	end
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		ldo_channel #(
			.UNIT_CYC(DELAY_UNIT_CYC)
		) u_ch (
			.pclk(pclk),
			.presetn(presetn),
			.on_bit(q.cfg[i][ldo_pkg::F_ON]),
			.delay_code(q.cfg[i][ldo_pkg::F_DLY +: ldo_pkg::DLY_W]),
			.dis_bit(q.cfg[i][ldo_pkg::F_DIS]),
			.bias_bit(q.cfg[i][ldo_pkg::F_BIAS]),
			.vcode(vapp[i]),
			.reg_en(reg_en[i]),
			.discharge_on(discharge_on[i]),
			.low_bias(low_bias[i]),
			.vout_mv(vout_mv[i*ldo_pkg::MV_W +: ldo_pkg::MV_W])
		);
	end
	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.err;
	assign irq_out_n = q.irq_n;
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_apb_ready;
		setup |=> pready ##1 !pready;
	endproperty
	a_apb_ready: assert property (p_apb_ready) else $error("pready not one access cycle");
	property p_default_v;
		!q.sys_en |-> vapp[0] == DEF_VCODE && vapp[3] == DEF_VCODE;
	endproperty
	a_default_v: assert property (p_default_v) else $error("code applied before enable");
	property p_pg_read;
		setup && !pwrite && paddr == ldo_pkg::CH_BASE
			|=> prdata[ldo_pkg::F_PG] == $past(pg_ok[0]);
	endproperty
	a_pg_read: assert property (p_pg_read) else $error("power-good flag wrong");
	property p_irq_set;
		|(fault & q.mask) |=> !irq_out_n;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("unmasked fault without irq");
	property p_irq_masked;
		q.mask == '0 |-> irq_out_n;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("masked fault raised irq");
	property p_irq_hold;
		!irq_out_n && !access |=> !irq_out_n;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq released without read");
	property p_ack;
		access && !pwrite && !q.err && ch_hit && fault[ch_idx] == 1'b0
			|=> q.stat[$past(ch_idx)] == 1'b0;
	endproperty
	a_ack: assert property (p_ack) else $error("read did not acknowledge fault");
	property p_or;
		irq_out_n == !(|(q.stat & q.mask));
	endproperty
	a_or: assert property (p_or) else $error("irq not OR of pending faults");
	property p_set_wins;
		|fault |=> (q.stat & $past(fault)) == $past(fault);
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("fault lost on clear");
	property p_indep;
		access && pwrite && ch_hit && ch_idx == 2'h0 |=> $stable(q.cfg[1]);
	endproperty
	a_indep: assert property (p_indep) else $error("write leaked to other channel");
	property p_err;
		setup && !ch_hit && paddr > ldo_pkg::IRQ_MASK |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	// ---------------------------------------------------------------
	// Bus checks
	// ---------------------------------------------------------------
	property p_ready_idle;
		!psel |=> !pready;
	endproperty
	a_ready_idle: assert property (p_ready_idle) else $error("pready without select");
	property p_ready_access;
		access |=> !pready;
	endproperty
	a_ready_access: assert property (p_ready_access) else $error("pready held past access");
	property p_rdata_hold;
		!setup |=> $stable(prdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved outside setup");
	property p_err_hold;
		!setup |=> $stable(pslverr);
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag moved outside setup");
	property p_cfg_read;
		setup && ch_hit |=> prdata[CFG_W-1:0] == $past(q.cfg[ch_idx]);
	endproperty
	a_cfg_read: assert property (p_cfg_read) else $error("channel settings read wrong");
	property p_cfg_read_top;
		setup && ch_hit |=> prdata[31:ldo_pkg::F_PG+1] == '0;
	endproperty
	a_cfg_read_top: assert property (p_cfg_read_top) else $error("unused channel bits not zero");
	property p_mapped_ok;
		setup && ch_hit |=> !pslverr;
	endproperty
	a_mapped_ok: assert property (p_mapped_ok) else $error("channel access refused");
	property p_sys_read;
		setup && paddr == ldo_pkg::SYS_EN |=> prdata == 32'($past(q.sys_en));
	endproperty
	a_sys_read: assert property (p_sys_read) else $error("system enable read wrong");
	property p_stat_read;
		setup && paddr == ldo_pkg::IRQ_STAT |=> prdata == 32'($past(q.stat));
	endproperty
	a_stat_read: assert property (p_stat_read) else $error("irq status read wrong");
	property p_mask_read;
		setup && paddr == ldo_pkg::IRQ_MASK |=> prdata == 32'($past(q.mask));
	endproperty
	a_mask_read: assert property (p_mask_read) else $error("irq unmask read wrong");
	property p_unaligned;
		setup && paddr[1:0] != 2'h0 |=> pslverr && prdata == 32'h0000_0000;
	endproperty
	a_unaligned: assert property (p_unaligned) else $error("unaligned access not refused");
	property p_cfg_write;
		access && pwrite && !q.err && ch_hit
			|=> q.cfg[$past(ch_idx)] == $past(pwdata[CFG_W-1:0]);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("channel write lost");
	property p_sys_write;
		access && pwrite && !q.err && paddr == ldo_pkg::SYS_EN
			|=> q.sys_en == $past(pwdata[0]);
	endproperty
	a_sys_write: assert property (p_sys_write) else $error("system enable write lost");
	property p_mask_write;
		access && pwrite && !q.err && paddr == ldo_pkg::IRQ_MASK
			|=> q.mask == $past(pwdata[NCH-1:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("unmask write lost");
	property p_err_no_write;
		access && q.err |=> $stable(q.cfg) && $stable(q.sys_en) && $stable(q.mask);
	endproperty
	a_err_no_write: assert property (p_err_no_write) else $error("refused write took effect");
	property p_read_no_write;
		access && !pwrite |=> $stable(q.cfg) && $stable(q.sys_en) && $stable(q.mask);
	endproperty
	a_read_no_write: assert property (p_read_no_write) else $error("read changed settings");
	property p_idle_no_write;
		!access |=> $stable(q.cfg) && $stable(q.sys_en) && $stable(q.mask);
	endproperty
	a_idle_no_write: assert property (p_idle_no_write) else $error("settings moved while idle");
	// ---------------------------------------------------------------
	// Interrupt checks
	// ---------------------------------------------------------------
	property p_w1c;
		access && pwrite && !q.err && paddr == ldo_pkg::IRQ_STAT
			|=> (q.stat & $past(pwdata[NCH-1:0]) & ~$past(fault)) == '0;
	endproperty
	a_w1c: assert property (p_w1c) else $error("status not cleared by write");
	property p_sticky;
		!access |=> (q.stat & $past(q.stat)) == $past(q.stat);
	endproperty
	a_sticky: assert property (p_sticky) else $error("status dropped without host");
	property p_set_source;
		1'b1 |=> (q.stat & ~$past(q.stat) & ~$past(fault)) == '0;
	endproperty
	a_set_source: assert property (p_set_source) else $error("status set without fault");
	property p_fault_edge;
		fault == ($past(pg_ok) & ~pg_ok);
	endproperty
	a_fault_edge: assert property (p_fault_edge) else $error("fault not a power-good drop");
	property p_mask_quiet;
		((q.stat | fault) & q.mask) == '0 && !(access && pwrite && paddr == ldo_pkg::IRQ_MASK)
			|=> irq_out_n;
	endproperty
	a_mask_quiet: assert property (p_mask_quiet) else $error("irq without unmasked fault");
	property p_release;
		$rose(irq_out_n) |-> $past(access);
	endproperty
	a_release: assert property (p_release) else $error("irq released without host access");
	// ---------------------------------------------------------------
	// Channel checks
	// ---------------------------------------------------------------
	property p_default_all;
		!q.sys_en |-> vapp == {NCH{DEF_VCODE}};
	endproperty
	a_default_all: assert property (p_default_all) else $error("code used before enable");
	property p_dis_excl;
		(discharge_on & reg_en) == '0;
	endproperty
	a_dis_excl: assert property (p_dis_excl) else $error("discharge on enabled channel");
	for (genvar i = 0; i < NCH; i++) begin : g_chk
		property p_bias_follow;
			@(posedge pclk) disable iff (!presetn)
			1'b1 |=> low_bias[i] == $past(q.cfg[i][ldo_pkg::F_BIAS]);
		endproperty
		a_bias_follow: assert property (p_bias_follow) else $error("bias drive wrong");
		property p_dis_follow;
			@(posedge pclk) disable iff (!presetn)
			1'b1 |=> discharge_on[i] == ($past(q.cfg[i][ldo_pkg::F_DIS]) && !reg_en[i]);
		endproperty
		a_dis_follow: assert property (p_dis_follow) else $error("discharge drive wrong");
		property p_off_quiet;
			@(posedge pclk) disable iff (!presetn)
			!$past(q.cfg[i][ldo_pkg::F_ON]) |-> !reg_en[i];
		endproperty
		a_off_quiet: assert property (p_off_quiet) else $error("enable with on bit clear");
		property p_code_applied;
			@(posedge pclk) disable iff (!presetn)
			q.sys_en |-> vapp[i] == q.cfg[i][ldo_pkg::F_VC +: ldo_pkg::VC_W];
		endproperty
		a_code_applied: assert property (p_code_applied) else $error("written code not used");
		property p_pg_flag;
			@(posedge pclk) disable iff (!presetn)
			setup && ch_hit && ch_idx == 2'(i)
				|=> prdata[ldo_pkg::F_PG] == $past(pg_ok[i]);
		endproperty
		a_pg_flag: assert property (p_pg_flag) else $error("power-good flag wrong");
		property p_read_ack;
			@(posedge pclk) disable iff (!presetn)
			access && !pwrite && !q.err && ch_hit && ch_idx == 2'(i) && !fault[i]
				|=> !q.stat[i];
		endproperty
		a_read_ack: assert property (p_read_ack) else $error("flag read did not clear");
		property p_fault_sets;
			@(posedge pclk) disable iff (!presetn)
			fault[i] |=> q.stat[i];
		endproperty
		a_fault_sets: assert property (p_fault_sets) else $error("fault not recorded");
		property p_stat_holds;
			@(posedge pclk) disable iff (!presetn)
			q.stat[i] && !access |=> q.stat[i];
		endproperty
		a_stat_holds: assert property (p_stat_holds) else $error("pending fault lost");
	end
endmodule : ldo_channel_control

// *** ldo_pkg.sv ***
/*
 * Constants shared by the linear regulator channel control.
 * Assumes a 50 MHz pclk and an APB3 master with 32-bit data.
 */
package ldo_pkg;
	// ---------------------------------------------------------------
	// Sizes
	// ---------------------------------------------------------------
	localparam int NCH = 4;
	localparam int VC_W = 6;
	localparam int DLY_W = 3;
	localparam int MV_W = 12;
	localparam int CFG_W = 12;
	localparam int ADDR_W = 8;
	// ---------------------------------------------------------------
	// Register map and fields
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CH_BASE = 8'h00;
	localparam logic [ADDR_W-1:0] SYS_EN = 8'h10;
	localparam logic [ADDR_W-1:0] IRQ_STAT = 8'h14;
	localparam logic [ADDR_W-1:0] IRQ_MASK = 8'h18;
	localparam int F_VC = 0;
	localparam int F_ON = 6;
	localparam int F_DLY = 7;
	localparam int F_DIS = 10;
	localparam int F_BIAS = 11;
	localparam int F_PG = 12;
	localparam logic [VC_W-1:0] DEF_VCODE = 6'h00;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ = 50000;
	localparam int DELAY_UNIT_MS = 2;
	localparam int DELAY_UNIT_CYC = DELAY_UNIT_MS * CLK_KHZ;
	// ---------------------------------------------------------------
	// Voltage grid in millivolts
	// ---------------------------------------------------------------
	localparam logic [MV_W-1:0] V_MIN_MV = 12'h258;
	localparam logic [MV_W-1:0] V_MAX_MV = 12'hF3C;
	function automatic logic [MV_W-1:0] vcode_to_mv(input logic [VC_W-1:0] c);
		logic [MV_W-1:0] base;
		logic [MV_W-1:0] step;
		base = 12'h258;
		step = 12'h19;
		unique case (c[5:3])
			3'h0: base = 12'h258;
			3'h1: base = 12'h320;
			3'h2: base = 12'h3E8;
			3'h3: base = 12'h4B0;
			3'h4: base = 12'h640;
			3'h5: base = 12'h7D0;
			3'h6: base = 12'h960;
			3'h7: base = 12'hC80;
		endcase
		if (c[5:3] >= 3'h6) begin
			step = 12'h64;
		end else if (c[5:3] >= 3'h3) begin
			step = 12'h32;
		end
		return MV_W'(base + step * {9'h000, c[2:0]});
	endfunction : vcode_to_mv
endpackage : ldo_pkg

// *** test_ldo_channel_control.sv ***
/*
 * Self-checking bench for ldo_channel_control over APB3.
 * Assumes ldo_pkg and ldo_analog_model are compiled first.
 */
`timescale 1ns/1ps
module test_ldo_channel_control;
	localparam int UNIT = 4;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, irq_out_n;
	logic [3:0] pg_ok, reg_en, discharge_on, low_bias, dip = 4'h0;
	logic [47:0] vout_mv;
	logic [5:0] vc[4];
	logic [31:0] cfgv[4];
	logic ds, bb;
	int failures = 0, checked = 0, n, c;
	always #10 pclk = ~pclk;
	ldo_channel_control #(.DELAY_UNIT_CYC(UNIT), .DEF_VCODE(6'h00)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pg_ok(pg_ok), .reg_en(reg_en),
		.discharge_on(discharge_on), .low_bias(low_bias), .vout_mv(vout_mv),
		.irq_out_n(irq_out_n));
	ldo_analog_model model (.pclk(pclk), .presetn(presetn), .dip(dip), .pg_ok(pg_ok));
	// -------------------------------------------
	// Helpers
	// -------------------------------------------
	task give_verdict();
		$display("checks %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			failures++;
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		// Master waits on pready, never on a fixed count
		while (pready !== 1'b1 && k < 20) begin
			k++;
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (k >= 20) begin
			failures++;
			give_verdict();
		end
	endtask : apb
	task settle(input int m);
		repeat (m) @(posedge pclk);
		#1;
	endtask : settle
	task wait_irq(input logic v);
		int k;
		k = 0;
		while (irq_out_n !== v && k < 20) begin
			@(posedge pclk);
			#1;
			k++;
		end
		chk("irq_out_n", v, irq_out_n);
		if (irq_out_n !== v) give_verdict();
	endtask : wait_irq
	function automatic logic [11:0] exp_mv(input logic [5:0] v);
		int b[8] = '{600, 800, 1000, 1200, 1600, 2000, 2400, 3200};
		int s;
		s = (v[5:3] < 3) ? 25 : ((v[5:3] < 6) ? 50 : 100);
		return 12'(b[v[5:3]] + s * v[2:0]);
	endfunction : exp_mv
	function automatic logic [31:0] cfg(input logic [5:0] v, input logic on,
		input logic [2:0] d, input logic s, input logic b);
		return {20'h00000, b, s, d, on, v};
	endfunction : cfg
	// -------------------------------------------
	// Sequence
	// -------------------------------------------
	initial begin
		void'($urandom(53));
		repeat (3) @(posedge pclk);
		presetn <= 1;
		settle(2);
		chk("irq_out_n", 1, irq_out_n);
		chk("reg_en", 0, reg_en);
		for (int i = 0; i < 4; i++) vc[i] = 6'($urandom);
		vc[0] = 6'h00;
		vc[1] = 6'h3F;
		for (int i = 0; i < 4; i++) begin
			cfgv[i] = cfg(vc[i], 0, 3'h0, 0, 0);
			apb(1, 8'(i * 4), cfgv[i]);
		end
		settle(4);
		for (int i = 0; i < 4; i++) chk("vout", 12'h258, vout_mv[i*12+:12]);
		apb(1, ldo_pkg::SYS_EN, 32'h1);
		settle(4);
		for (int i = 0; i < 4; i++) chk("vout", exp_mv(vc[i]), vout_mv[i*12+:12]);
		for (int d = 0; d < 8; d++) begin
			c = d % 4;
			ds = 1'($urandom);
			bb = 1'($urandom);
			apb(1, 8'(c * 4), cfg(vc[c], 0, 3'(d), ds, bb));
			settle(3);
			chk("discharge_on", ds, discharge_on[c]);
			chk("low_bias", bb, low_bias[c]);
			apb(1, 8'(c * 4), cfg(vc[c], 1, 3'(d), ds, bb));
			n = 0;
			while (reg_en[c] !== 1'b1 && n < 400) begin
				@(posedge pclk);
				#1;
				n++;
			end
			chk("turn_on_delay", (d == 0) ? 1 : (UNIT << (d - 1)) + 1, n);
			if (reg_en[c] !== 1'b1) give_verdict();
			settle(1);
			chk("discharge_on", 0, discharge_on[c]);
			apb(1, 8'(c * 4), cfg(vc[c], 1, 3'(d), ds, bb));
			settle(3);
			chk("reg_en", 1, reg_en[c]);
			cfgv[c] = cfg(vc[c], 0, 3'(d), ds, bb);
			apb(1, 8'(c * 4), cfgv[c]);
			settle(3);
			chk("reg_en", 0, reg_en[c]);
		end
		apb(1, 8'h04, cfg(vc[1], 1, 3'h7, 0, 0));
		apb(1, 8'h04, cfgv[1]);
		settle(300);
		chk("reg_en", 0, reg_en[1]);
		for (int i = 0; i < 4; i++) begin
			apb(0, 8'(i * 4), 32'h0);
			chk("channel reg", cfgv[i] | 32'h1000, rd);
		end
		// Faults on two unmasked channels, then on a masked one, then on channel 3 once it is unmasked
		apb(1, ldo_pkg::IRQ_MASK, 32'h3);
		dip[0] <= 1;
		wait_irq(0);
		apb(1, ldo_pkg::IRQ_MASK, 32'h3);
		dip <= 4'h2;
		settle(4);
		dip <= 4'h0;
		settle(5);
		chk("irq_out_n", 0, irq_out_n);
		apb(0, ldo_pkg::IRQ_STAT, 32'h0);
		chk("irq status", 32'h3, rd);
		apb(0, 8'h00, 32'h0);
		settle(3);
		chk("irq_out_n", 0, irq_out_n);
		apb(0, 8'h04, 32'h0);
		wait_irq(1);
		dip[2] <= 1;
		settle(4);
		chk("irq_out_n", 1, irq_out_n);
		apb(0, 8'h08, 32'h0);
		chk("power good", 0, rd[12]);
		dip[2] <= 0;
		apb(1, ldo_pkg::IRQ_MASK, 32'h8);
		dip[3] <= 1;
		wait_irq(0);
		dip[3] <= 0;
		apb(1, ldo_pkg::IRQ_STAT, 32'h8);
		wait_irq(1);
		apb(0, 8'h1C, 32'h0);
		chk("pslverr", 1, er);
		chk("prdata", 0, rd);
		give_verdict();
	end
endmodule : test_ldo_channel_control
